// ===== rtl/dpam_pkg.sv
// Functional notes
// [R1] Device writes only under select, write, byte overlap
// [R2] Address changes only while write strobe high
// [R3] Array or flag space selected, stable through write
// [R4] Device data pins stay off during write
// [R5] Flag read drives all sixteen data lines
// [R6] Free flag reads all ones on both ports
// [R7] Earlier flag request wins outside contention window
// [R8] Master grants first valid port, flags other
// [R9] Near-simultaneous arrivals still flag exactly one port
// [R10] Collision flag drops on mismatch or deselect
// [R11] Write blocked while collision flag is low
// [R12] Hold write strobe after collision flag rises
// [R13] Stretch write pulse when output enable low
// [R14] Written data reaches far port within delay
// [R15] Left write at FFF raises right mailbox
// [R16] Right read at FFF clears right mailbox
// [R17] Right write at FFE raises left mailbox
// [R18] Left read at FFE clears left mailbox
// [R19] Mailbox access ignored under own collision flag
// [R20] Mailbox flags put in known state after power-up
// [R21] Eight flags on low address bits, bit 0 written
// [R22] Zero claims free flag; one hands over
// [R23] Both collision flags never low together
package dpam_pkg;

   // Pin widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;

   // Mailbox locations
   localparam logic [11:0] MBOX_LEFT_ADDR  = 12'hffe;
   localparam logic [11:0] MBOX_RIGHT_ADDR = 12'hfff;

   // Clock rate and pin timing, times in ns
   localparam int CLK_MHZ    = 40;
   localparam int T_WP_NS    = 50;
   localparam int T_WZ_NS    = 30;
   localparam int T_DW_NS    = 40;
   localparam int T_WH_NS    = 25;
   localparam int T_AA_NS    = 70;
   localparam int T_PULSE_NS = (T_WP_NS > T_WZ_NS + T_DW_NS) ? T_WP_NS : T_WZ_NS + T_DW_NS;

   // Least times round up to whole cycles
   localparam int TIMER_W = 4;
   localparam logic [TIMER_W-1:0] PULSE_CYC = TIMER_W'((T_PULSE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [TIMER_W-1:0] WH_CYC    = TIMER_W'((T_WH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [TIMER_W-1:0] READ_CYC  = TIMER_W'((T_AA_NS * CLK_MHZ + 999) / 1000);

   // User commands
   typedef enum logic [2:0] {
      CMD_READ,
      CMD_WRITE,
      CMD_SEM_READ,
      CMD_SEM_WRITE,
      CMD_MAIL_SEND,
      CMD_MAIL_TAKE
   } dpam_cmd_t;

   // Controller states
   typedef enum logic [2:0] {
      ST_INIT,
      ST_IDLE,
      ST_SETUP,
      ST_PULSE,
      ST_HOLD,
      ST_READ
   } dpam_state_t;

   // Whole controller state
   typedef struct packed {
      dpam_state_t       st;
      logic [11:0]       addr;
      logic [15:0]       dout;
      logic              data_oe_n;
      logic              cs_n;
      logic              rw_n;
      logic              oe_n;
      logic              ub_n;
      logic              lb_n;
      logic              sem_n;
      logic              blocked;
      logic              init_done;
      logic              rsp_valid;
      logic [15:0]       rsp_data;
   } dpam_ctrl_t;

   localparam dpam_ctrl_t CTRL_RESET = '{
      st: ST_INIT, addr: 12'h000, dout: 16'h0000, data_oe_n: 1'b1, cs_n: 1'b1,
      rw_n: 1'b1, oe_n: 1'b1, ub_n: 1'b1, lb_n: 1'b1, sem_n: 1'b1, blocked: 1'b0,
      init_done: 1'b0, rsp_valid: 1'b0, rsp_data: 16'h0000};

   // Timer state
   typedef struct packed {
      logic [TIMER_W-1:0] count;
   } dpam_timer_t;

   localparam dpam_timer_t TIMER_RESET = '{count: 4'h0};

endpackage

// ===== rtl/dpam_timer.sv
`timescale 1ns/1ps
module dpam_timer
   import dpam_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic                       ce,
   // Load and status
   input  wire logic                       load,
   input  wire logic [dpam_pkg::TIMER_W-1:0] load_val,
   output logic                            expired
);
   import dpam_pkg::*;

   dpam_timer_t s;
   dpam_timer_t next_s;

   // Down count, loads take priority
   always_comb
   begin
      next_s = s;
      if (load)
      begin
         next_s.count = load_val;
      end
      else if (s.count != 4'h0)
      begin
         next_s.count = s.count - 4'h1;
      end
   end

   // State register, frozen while ce low
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s <= TIMER_RESET;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   assign expired = (s.count == 4'h0);

endmodule // dpam_timer

// ===== rtl/dpam_port_ctrl.sv
`timescale 1ns/1ps
module dpam_port_ctrl
   import dpam_pkg::*;
#(
   parameter bit PORT_IS_LEFT = 1'b1
)
(
   // Clock, reset, enable
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic                     ce,
   // User request
   input  wire logic                     req_valid,
   output logic                          req_ready,
   input  wire dpam_pkg::dpam_cmd_t      req_cmd,
   input  wire logic [dpam_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [dpam_pkg::DATA_W-1:0] req_data,
   input  wire logic [1:0]               req_be,
   // User answer and status
   output logic                          rsp_valid,
   output logic [dpam_pkg::DATA_W-1:0]   rsp_data,
   output logic                          mail_pending,
   output logic                          collision_seen,
   // Memory port pins
   output logic [dpam_pkg::ADDR_W-1:0]   addr,
   output logic [dpam_pkg::DATA_W-1:0]   data_out,
   input  wire logic [dpam_pkg::DATA_W-1:0] data_in,
   output logic                          data_oe_n,
   output logic                          chip_select_n,
   output logic                          read_write_n,
   output logic                          output_enable_n,
   output logic                          upper_byte_enable_n,
   output logic                          lower_byte_enable_n,
   output logic                          flag_space_select_n,
   input  wire logic                     collision_flag_n,
   input  wire logic                     mailbox_irq_n
);
   import dpam_pkg::*;

   // Own mailbox is cleared by a read, peer mailbox raised by a write
   localparam logic [11:0] OWN_MBOX  = PORT_IS_LEFT ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR;
   localparam logic [11:0] PEER_MBOX = PORT_IS_LEFT ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR;

   dpam_ctrl_t         s;
   dpam_ctrl_t         next_s;
   logic               t_load;
   logic [TIMER_W-1:0] t_val;
   logic               t_expired;

   dpam_timer u_timer (
      .clk      (clk),
      .resetn   (resetn),
      .ce       (ce),
      .load     (t_load),
      .load_val (t_val),
      .expired  (t_expired)
   );

   // Requests only taken between accesses, after the start-up clear
   assign req_ready = ce && s.init_done && (s.st == ST_IDLE);

   // Next-state logic for the whole port sequence
   always_comb
   begin
      next_s           = s;
      next_s.rsp_valid = 1'b0;
      t_load           = 1'b0;
      t_val            = READ_CYC;
      case (s.st)
         ST_INIT:
         begin
            // Own mailbox read puts our flag high after power-up [R20]
            next_s.addr = OWN_MBOX;
            next_s.cs_n = 1'b0;
            next_s.oe_n = 1'b0;
            next_s.ub_n = 1'b0;
            next_s.lb_n = 1'b0;
            next_s.st   = ST_READ;
            t_load      = 1'b1;
         end
         ST_IDLE:
         begin
            if (req_valid && req_ready)
            begin
               // Address moves only here and in ST_INIT, with strobe and select high [R2]
               next_s.addr  = req_addr;
               next_s.ub_n  = ~req_be[1];
               next_s.lb_n  = ~req_be[0];
               next_s.cs_n  = 1'b0;
               next_s.sem_n = 1'b1;
               next_s.dout  = req_data;
               case (req_cmd)
                  CMD_SEM_READ, CMD_SEM_WRITE:
                  begin
                     // Flag space: select high, flag select low, A2..A0 only [R3] [R21]
                     next_s.addr  = {9'h000, req_addr[2:0]};
                     next_s.cs_n  = 1'b1;
                     next_s.sem_n = 1'b0;
                     next_s.ub_n  = 1'b1;
                     next_s.lb_n  = 1'b1;
                     next_s.dout  = {15'h0000, req_data[0]}; // [R21] [R22]
                  end
                  CMD_MAIL_SEND:
                  begin
                     next_s.addr = PEER_MBOX; // [R15] [R17]
                  end
                  CMD_MAIL_TAKE:
                  begin
                     next_s.addr = OWN_MBOX; // [R16] [R18]
                  end
                  default:
                  begin
                  end
               endcase
               if (req_cmd == CMD_WRITE || req_cmd == CMD_SEM_WRITE ||
                   req_cmd == CMD_MAIL_SEND)
               begin
                  next_s.st = ST_SETUP;
               end
               else
               begin
                  next_s.oe_n = 1'b0;
                  next_s.st   = ST_READ;
                  t_load      = 1'b1;
               end
            end
         end
         ST_SETUP:
         begin
            // Output enable stays high, so the drivers are already off
            next_s.rw_n      = 1'b0;
            next_s.data_oe_n = 1'b0;
            next_s.st        = ST_PULSE;
            t_load           = 1'b1;
            t_val            = PULSE_CYC; // [R13]
         end
         ST_PULSE:
         begin
            if (!collision_flag_n)
            begin
               next_s.blocked = 1'b1; // [R11]
            end
            else if (s.blocked)
            begin
               // Deferred write needs a hold after the flag rises [R12]
               next_s.blocked = 1'b0;
               next_s.st      = ST_HOLD;
               t_load         = 1'b1;
               t_val          = WH_CYC;
            end
            else if (t_expired)
            begin
               next_s.rw_n      = 1'b1;
               next_s.data_oe_n = 1'b1;
               next_s.cs_n      = 1'b1;
               next_s.sem_n     = 1'b1;
               next_s.ub_n      = 1'b1;
               next_s.lb_n      = 1'b1;
               next_s.rsp_valid = 1'b1;
               next_s.st        = ST_IDLE;
            end
         end
         ST_HOLD:
         begin
            if (!collision_flag_n)
            begin
               next_s.blocked = 1'b1;
               next_s.st      = ST_PULSE; // [R11]
            end
            else if (t_expired)
            begin
               next_s.rw_n      = 1'b1;
               next_s.data_oe_n = 1'b1;
               next_s.cs_n      = 1'b1;
               next_s.sem_n     = 1'b1;
               next_s.ub_n      = 1'b1;
               next_s.lb_n      = 1'b1;
               next_s.rsp_valid = 1'b1;
               next_s.st        = ST_IDLE;
            end
         end
         ST_READ:
         begin
            if (t_expired)
            begin
               // Flag reads show the value on all lines [R5] [R6]
               next_s.rsp_data  = data_in;
               next_s.rsp_valid = s.init_done;
               next_s.init_done = 1'b1;
               next_s.cs_n      = 1'b1;
               next_s.oe_n      = 1'b1;
               next_s.sem_n     = 1'b1;
               next_s.ub_n      = 1'b1;
               next_s.lb_n      = 1'b1;
               next_s.st        = ST_IDLE;
            end
         end
         default:
         begin
            next_s = CTRL_RESET;
         end
      endcase
   end

   // State register, frozen while ce low
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s <= CTRL_RESET;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   // Pins and user outputs straight from flip-flops, except mail_pending and req_ready
   assign addr                = s.addr;
   assign data_out            = s.dout;
   assign data_oe_n           = s.data_oe_n;
   assign chip_select_n       = s.cs_n;
   assign read_write_n        = s.rw_n;
   assign output_enable_n     = s.oe_n;
   assign upper_byte_enable_n = s.ub_n;
   assign lower_byte_enable_n = s.lb_n;
   assign flag_space_select_n = s.sem_n;
   assign rsp_valid           = s.rsp_valid;
   assign rsp_data            = s.rsp_data;
   assign collision_seen      = s.blocked;
   // Inputs are synchronous, so the flag is passed as a level
   assign mail_pending        = ~mailbox_irq_n;

   // Address moves only with the strobe high
   addr_stable_a: assert property (@(posedge clk) disable iff (!resetn) // [R2]
      $changed(addr) |-> read_write_n && $past(read_write_n))
      else $error("address changed during write strobe");

   // Array and flag space never selected together
   sel_exclusive_a: assert property (@(posedge clk) disable iff (!resetn) // [R3]
      !flag_space_select_n |-> chip_select_n)
      else $error("flag space and array selected together");

   // Selects steady through the whole write
   sel_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [R3]
      (!read_write_n && $past(!read_write_n)) |->
      $stable(chip_select_n) && $stable(flag_space_select_n) && $stable(addr))
      else $error("select moved during write");

   // Collision keeps the strobe low
   busy_block_a: assert property (@(posedge clk) disable iff (!resetn || !ce) // [R11]
      (!read_write_n && !collision_flag_n) |=> !read_write_n)
      else $error("write ended while collision flag low");

   // Strobe held past the collision release
   hold_after_a: assert property (@(posedge clk) disable iff (!resetn || !ce) // [R12]
      ($rose(collision_flag_n) && !read_write_n) |=> !read_write_n ##1 !read_write_n)
      else $error("write not held after collision release");

   // Write pulse long enough for the stretched width
   pulse_width_a: assert property (@(posedge clk) disable iff (!resetn) // [R13]
      $rose(read_write_n) |-> !$past(read_write_n, 3) && !$past(read_write_n, 2))
      else $error("write pulse too short");

   // Data driven only inside the write strobe, outputs off
   data_drive_a: assert property (@(posedge clk) disable iff (!resetn) // [R4]
      !data_oe_n |-> !read_write_n && output_enable_n)
      else $error("data driven outside write strobe");

   // First access after reset clears the own mailbox
   init_clear_a: assert property (@(posedge clk) disable iff (!resetn) // [R20]
      (!chip_select_n && s.st == ST_READ && !s.init_done) |->
      addr == OWN_MBOX && !output_enable_n && read_write_n)
      else $error("start-up mailbox clear malformed");

   // Flag writes carry only bit 0
   sem_bit0_a: assert property (@(posedge clk) disable iff (!resetn) // [R21]
      (!flag_space_select_n && !data_oe_n) |-> data_out[15:1] == 15'h0000 &&
      addr[11:3] == 9'h000)
      else $error("flag write with stray bits");

endmodule // dpam_port_ctrl

// ===== dv/dpam_dev_model.sv
`timescale 1ns/1ps
module dpam_dev_model
   import dpam_pkg::*;
#(
   parameter int ACC_NS = 0
)
(
   // Pins of both ports, index 0 is left
   input  wire logic [11:0] addr  [2],
   input  wire logic [15:0] din   [2],
   input  wire logic        cs_n  [2],
   input  wire logic        rw_n  [2],
   input  wire logic        oe_n  [2],
   input  wire logic        ube_n [2],
   input  wire logic        lbe_n [2],
   input  wire logic        fs_n  [2],
   // Device outputs
   output logic [15:0]      dq    [2],
   output logic             cf_n  [2],
   output logic             irq_n [2]
);
   logic [15:0] mem  [4096];
   logic [15:0] last [2];
   logic        drv  [2];
   logic        sa   [2];
   logic        sb   [2];
   logic [2:0]  sk   [2];
   logic        rq   [2][8];
   int          own  [8];
   realtime     tv   [2];
   logic        match;
   logic        won;
   logic        lose_r;

   // Flags power up asserted; owners must clear them
   initial
   begin
      irq_n = '{1'b0, 1'b0};
      last = '{16'h0000, 16'h0000};
      won = 1'b0;
      lose_r = 1'b0;
      foreach (own[k]) own[k] = 2;
      foreach (rq[p, k]) rq[p][k] = 1'b0;
   end

   // Arrival of address and select per port
   always @(cs_n[0] or addr[0]) tv[0] = $realtime;
   always @(cs_n[1] or addr[1]) tv[1] = $realtime;
   assign match = !cs_n[0] && !cs_n[1] && addr[0] == addr[1];

   // Later arrival loses; a tie goes against the right port
   always @(posedge match)
   begin
      #1 lose_r = (tv[1] >= tv[0]);
      won = match;
   end
   always @(negedge match) won = 1'b0;
   assign cf_n[0] = !(won && !lose_r);
   assign cf_n[1] = !(won && lose_r);

   // Array, mailbox and flag writes; array and mailbox gated by own collision flag, flag writes not
   always @*
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (!cs_n[i] && !rw_n[i] && cf_n[i])
         begin
            if (fs_n[i] && !lbe_n[i]) mem[addr[i]][7:0] = din[i][7:0];
            if (fs_n[i] && !ube_n[i]) mem[addr[i]][15:8] = din[i][15:8];
            if (addr[i] == (i ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR))
               irq_n[1-i] = 1'b0;
         end
         if (!cs_n[i] && !oe_n[i] && cf_n[i] &&
             addr[i] == (i ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR))
            irq_n[i] = 1'b1;
         sa[i] = !fs_n[i] && (cs_n[i] || (ube_n[i] && lbe_n[i])) && !rw_n[i];
         if (sa[i])
         begin
            sb[i] = din[i][0];
            sk[i] = addr[i][2:0];
         end
      end
   end
   always @(negedge sa[0]) flag_write(0, sb[0], sk[0]);
   always @(negedge sa[1]) flag_write(1, sb[1], sk[1]);

   // Zero claims a free flag; one hands it to a waiting port
   task automatic flag_write(input int p, input logic b, input logic [2:0] k);
      if (!b)
      begin
         rq[p][k] = 1'b1;
         if (own[k] == 2) own[k] = p;
      end
      else
      begin
         rq[p][k] = 1'b0;
         if (own[k] == p) own[k] = rq[1-p][k] ? 1 - p : 2;
      end
   endtask

   // Read path; released lines show the inverse of the last value
   always @*
   begin
      for (int i = 0; i < 2; i++)
      begin
         drv[i] = !oe_n[i] && rw_n[i];
         if (drv[i] && !fs_n[i] && (cs_n[i] || (ube_n[i] && lbe_n[i])))
            last[i] = {16{own[addr[i][2:0]] != i}};
         else if (drv[i] && !cs_n[i] && fs_n[i] && !(ube_n[i] && lbe_n[i]))
            last[i] = mem[addr[i]];
         else
            drv[i] = 1'b0;
      end
   end
   assign #(ACC_NS) dq[0] = drv[0] ? last[0] : ~last[0];
   assign #(ACC_NS) dq[1] = drv[1] ? last[1] : ~last[1];
endmodule // dpam_dev_model

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
   import dpam_pkg::*;
   logic        clk;
   logic        resetn;
   logic        ce;
   logic        rv    [2];
   dpam_cmd_t   cmd   [2];
   logic [11:0] ra    [2];
   logic [15:0] rdat  [2];
   logic [1:0]  be    [2];
   logic        hit   [2];
   wire         rdy   [2];
   wire         rsv   [2];
   wire  [15:0] rsd   [2];
   wire         mp    [2];
   wire         cseen [2];
   wire  [11:0] pa    [2];
   wire  [15:0] pd    [2];
   wire         doe_n [2];
   wire  [15:0] wd    [2];
   wire  [15:0] dq    [2];
   wire         cs_n  [2];
   wire         rw_n  [2];
   wire         oe_n  [2];
   wire         ube_n [2];
   wire         lbe_n [2];
   wire         fs_n  [2];
   wire         cf_n  [2];
   wire         irq_n [2];
   int          err_total;
   int          num_checks;

   // Left and right controllers on one shared device
   for (genvar g = 0; g < 2; g++)
   begin : g_port
      dpam_port_ctrl #(.PORT_IS_LEFT(1'(g == 0))) i_dut (
         .clk(clk), .resetn(resetn), .ce(ce), .req_valid(rv[g]), .req_ready(rdy[g]),
         .req_cmd(cmd[g]), .req_addr(ra[g]), .req_data(rdat[g]), .req_be(be[g]),
         .rsp_valid(rsv[g]), .rsp_data(rsd[g]), .mail_pending(mp[g]),
         .collision_seen(cseen[g]), .addr(pa[g]), .data_out(pd[g]), .data_in(dq[g]),
         .data_oe_n(doe_n[g]), .chip_select_n(cs_n[g]), .read_write_n(rw_n[g]),
         .output_enable_n(oe_n[g]), .upper_byte_enable_n(ube_n[g]),
         .lower_byte_enable_n(lbe_n[g]), .flag_space_select_n(fs_n[g]),
         .collision_flag_n(cf_n[g]), .mailbox_irq_n(irq_n[g]));
      // Undriven bus shows junk; 1 ns lag keeps the strobe edge ahead of data
      assign #1 wd[g] = doe_n[g] ? ~pd[g] : pd[g];
   end
   dpam_dev_model #(.ACC_NS(60)) i_dev (
      .addr(pa), .din(wd), .cs_n(cs_n), .rw_n(rw_n), .oe_n(oe_n), .ube_n(ube_n),
      .lbe_n(lbe_n), .fs_n(fs_n), .dq(dq), .cf_n(cf_n), .irq_n(irq_n));

   // Clock, 25 ns period
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Remember which port ever saw its write blocked
   always @(posedge clk) for (int i = 0; i < 2; i++) if (cseen[i] === 1'b1) hit[i] <= 1'b1;

   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // One user request, held until taken, then wait for its answer
   task automatic do_op(input int p, input dpam_cmd_t c, input logic [11:0] a,
                        input logic [15:0] d, input logic [1:0] b, output logic [15:0] q);
      int n;
      n = 0;
      @(posedge clk);
      rv[p] <= 1'b1;
      cmd[p] <= c;
      ra[p] <= a;
      rdat[p] <= d;
      be[p] <= b;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (rdy[p] !== 1'b1 && n < 200);
      @(posedge clk);
      rv[p] <= 1'b0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (rsv[p] !== 1'b1 && n < 400);
      q = rsd[p];
      check(n < 400, "request timed out");
   endtask

   task automatic t_init;
      int n;
      n = 0;
      while ((rdy[0] !== 1'b1 || rdy[1] !== 1'b1) && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      check(mp[0] === 1'b0 && mp[1] === 1'b0, "mailbox not cleared");
   endtask

   task automatic t_array;
      logic [15:0] q;
      do_op(0, CMD_WRITE, 12'h010, 16'h1234, 2'b11, q);
      do_op(1, CMD_READ, 12'h010, 16'h0000, 2'b11, q);
      check(q === 16'h1234, "word not seen across");
      do_op(1, CMD_WRITE, 12'h010, 16'habcd, 2'b01, q);
      do_op(0, CMD_READ, 12'h010, 16'h0000, 2'b11, q);
      check(q === 16'h12cd, "byte write wrong");
   endtask

   task automatic t_flag;
      logic [15:0] q;
      logic [15:0] q2;
      for (int k = 0; k < 8; k += 7)
      begin
         do_op(0, CMD_SEM_WRITE, 12'(k), 16'h0000, 2'b00, q);
         do_op(1, CMD_SEM_WRITE, 12'(k), 16'h0000, 2'b00, q);
         do_op(0, CMD_SEM_READ, 12'(k), 16'h0000, 2'b00, q);
         do_op(1, CMD_SEM_READ, 12'(k), 16'h0000, 2'b00, q2);
         check(q === 16'h0000 && q2 === 16'hffff, "claim wrong");
         do_op(0, CMD_SEM_WRITE, 12'(k), 16'h0001, 2'b00, q);
         do_op(1, CMD_SEM_READ, 12'(k), 16'h0000, 2'b00, q);
         check(q === 16'h0000, "handover lost");
         do_op(1, CMD_SEM_WRITE, 12'(k), 16'h0001, 2'b00, q);
         do_op(0, CMD_SEM_READ, 12'(k), 16'h0000, 2'b00, q);
         check(q === 16'hffff, "free flag not ones");
      end
      fork
         do_op(0, CMD_SEM_WRITE, 12'h003, 16'h0000, 2'b00, q);
         do_op(1, CMD_SEM_WRITE, 12'h003, 16'h0000, 2'b00, q2);
      join
      do_op(0, CMD_SEM_READ, 12'h003, 16'h0000, 2'b00, q);
      do_op(1, CMD_SEM_READ, 12'h003, 16'h0000, 2'b00, q2);
      check((q ^ q2) === 16'hffff, "contention not single winner");
   endtask

   task automatic t_mail;
      logic [15:0] q;
      for (int p = 0; p < 2; p++)
      begin
         do_op(p, CMD_MAIL_SEND, 12'h000, 16'(16'h5a00 + p), 2'b11, q);
         check(mp[1-p] === 1'b1 && mp[p] === 1'b0, "mail not raised");
         do_op(1 - p, CMD_MAIL_TAKE, 12'h000, 16'h0000, 2'b11, q);
         check(q === 16'(16'h5a00 + p) && mp[1-p] === 1'b0, "mail not taken");
      end
   endtask

   // Same address from both ports in one cycle; right must defer
   task automatic t_coll;
      logic [15:0] q;
      logic [15:0] q2;
      hit = '{1'b0, 1'b0};
      fork
         do_op(0, CMD_WRITE, 12'h020, 16'h1111, 2'b11, q);
         do_op(1, CMD_WRITE, 12'h020, 16'h2222, 2'b11, q2);
      join
      check(hit[1] === 1'b1 && hit[0] === 1'b0, "block on wrong port");
      do_op(0, CMD_READ, 12'h020, 16'h0000, 2'b11, q);
      check(q === 16'h2222, "deferred write lost");
   endtask

   // Enable low mid-write freezes pins and handshake; write still lands
   task automatic t_freeze;
      logic [15:0] q;
      fork
         do_op(0, CMD_WRITE, 12'h030, 16'h3c3c, 2'b11, q);
         begin
            repeat (3) @(posedge clk);
            ce <= 1'b0;
            repeat (3) @(posedge clk);
            @(negedge clk);
            check(rw_n[0] === 1'b0 && cs_n[0] === 1'b0 && rdy[1] === 1'b0, "freeze lost");
            @(posedge clk);
            ce <= 1'b1;
         end
      join
      do_op(1, CMD_READ, 12'h030, 16'h0000, 2'b11, q);
      check(q === 16'h3c3c, "write lost across freeze");
   endtask

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Watchdog, far beyond the expected run
   initial
   begin
      #500000;
      err_total++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      err_total = 0;
      num_checks = 0;
      resetn = 1'b0;
      ce = 1'b1;
      rv = '{1'b0, 1'b0};
      cmd = '{CMD_READ, CMD_READ};
      ra = '{12'h000, 12'h000};
      rdat = '{16'h0000, 16'h0000};
      be = '{2'b00, 2'b00};
      hit = '{1'b0, 1'b0};
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      t_init();
      t_array();
      t_flag();
      t_mail();
      t_coll();
      t_freeze();
      give_verdict();
   end
endmodule // tb
